// ==== rtl/lms_mode_seq.sv ====
// Purpose: operating modes and boost control of the lighting unit
// Assumes: clk is the internal oscillator; pins are asynchronous
// Notes: registers are reached over the two-wire serial bus
//
// Overview of operation
// - reset mode returns every internal register to its default
// - power-on reset active at startup; on release go to standby
// - run-request bit reads zero after power-on reset
// - standby with functions off while run-request is zero
// - writes accepted in standby, acting once startup completes
// - run-request high starts startup with a 10ms oscillator delay
// - thermal shutdown holds the device in startup until it clears
// - boost startup after startup if boost enabled, or from normal
// - boost runs 20ms in low-current pulse mode, then normal pulses
// - all LED outputs forced off during the 20ms soft start
// - boost enable low puts the converter in its own standby
// - normal mode accepts writes in any order, any bits at once
// - boost output value 8 to 20 selects that many volts
// - boost output value below 8 is used as 8
// - boost output value above 20 is used as 20
// - active load on by default; off allows pulse skipping
// - at least a minimum-width switch pulse every period
// - maximum duty cycle limited by digital logic
// - switching rate derived from the internal oscillator
// - boost output setting lives at offset 0DH, 08H is 8V
`timescale 1ns/100ps
`include "lms_defs.svh"
module lms_mode_seq #(
  parameter int STARTUP_CYC =
    `LMS_STARTUP_MS * (`LMS_CLK_HZ / 1000),
  parameter int SOFTSTART_CYC =
    `LMS_SOFTSTART_MS * (`LMS_CLK_HZ / 1000),
  parameter logic [6:0] BUS_ADDR = `LMS_BUS_ADDR
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic externalResetLow,
  input wire logic porActive,
  input wire logic thermalShutdownEvent,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic currentTrip,
  input wire logic feedbackHigh,
  output logic sdaOut,
  output logic sdaOe_n,
  output lms_pkg::lms_mode_type modeOut,
  output logic internalBlocksOn,
  output logic ledForceOff,
  output logic boostSoftStart,
  output logic boostSwitch,
  output logic activeLoadOn,
  output logic [7:0] boostOutSetting
);
  import lms_pkg::*;

  // counts from the nominal oscillator rate
  localparam int PERIOD_CYC = `LMS_CLK_HZ / `LMS_SWITCH_HZ;
  localparam int MIN_RAW =
    (`LMS_MIN_PULSE_NS + `LMS_CLK_PERIOD_NS - 1) / `LMS_CLK_PERIOD_NS;
  localparam int MIN_ON_CYC = (MIN_RAW < 1) ? 1 : MIN_RAW;
  localparam int MAX_ON_CYC = PERIOD_CYC * `LMS_MAX_DUTY_PCT / 100;
  localparam int SOFT_RAW = PERIOD_CYC * `LMS_SOFT_DUTY_PCT / 100;
  localparam int SOFT_ON_CYC = (SOFT_RAW < MIN_ON_CYC) ? MIN_ON_CYC
                                                        : SOFT_RAW;
  localparam int NSYNC = 7;
  // idle levels: resets asserted, bus lines released high
  localparam logic [NSYNC-1:0] SYNC_INIT = 7'h2C;

  if (STARTUP_CYC < 1 || SOFTSTART_CYC < 1) begin : g_chk
    $error("startup delays must be at least one cycle");
  end

  // input synchronisers
  logic [NSYNC-1:0] pinRaw;
  logic [NSYNC-1:0] syncAReg;
  logic [NSYNC-1:0] syncBReg;
  logic extRstLowS;
  logic porS;
  logic tsdS;
  logic sclS;
  logic sdaS;
  logic tripS;
  logic fbHighS;
  logic sclDlyReg;
  logic sdaDlyReg;
  logic chipReset;

  // register file
  logic [7:0] ctrlReg;
  logic [7:0] boostOutReg;
  logic runReq;
  logic boostEn;
  logic loadEn;
  logic [7:0] readData;

  // bus engine
  lms_bus_type busState;
  logic [3:0] bitCntReg;
  logic [7:0] shiftReg;
  logic [7:0] ptrReg;
  logic rwReg;
  logic masterNackReg;
  logic wrStrobeReg;
  logic [7:0] wrAddrReg;
  logic [7:0] wrDataReg;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic byteDone;

  // sequencer
  lms_mode_type modeReg;
  logic boostActiveReg;
  logic startupDone;
  logic softDone;
  logic startupClear;
  logic softClear;
  logic boostRun;

  assign pinRaw = {externalResetLow, porActive, thermalShutdownEvent,
                   sclIn, sdaIn, currentTrip, feedbackHigh};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      syncAReg <= SYNC_INIT;
      syncBReg <= SYNC_INIT;
    end else begin
      syncAReg <= pinRaw;
      syncBReg <= syncAReg;
    end
  end

  assign {extRstLowS, porS, tsdS, sclS, sdaS, tripS, fbHighS} = syncBReg;

  // either reset source holds the whole block in reset mode
  assign chipReset = !rst_n || porS || !extRstLowS;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclDlyReg <= 1'b1;
      sdaDlyReg <= 1'b1;
    end else begin
      sclDlyReg <= sclS;
      sdaDlyReg <= sdaS;
    end
  end

  assign sclRise = sclS && !sclDlyReg;
  assign sclFall = !sclS && sclDlyReg;
  assign startSeen = sclS && sclDlyReg && sdaDlyReg && !sdaS;
  assign stopSeen = sclS && sclDlyReg && !sdaDlyReg && sdaS;
  assign byteDone = (bitCntReg == 4'h8);

  // read mux; unmapped offsets read as zero
  always_comb begin
    readData = 8'h00;
    if (ptrReg == `LMS_ADDR_BOOST_OUT) begin
      readData = boostOutReg;
    end else if (ptrReg == `LMS_ADDR_CTRL) begin
      readData = ctrlReg;
    end else if (ptrReg == `LMS_ADDR_STATUS) begin
      readData = {5'h00, modeReg};
    end
  end

  // two-wire slave: pointer byte then data, pointer auto-increments
  always_ff @(posedge clk) begin
    wrStrobeReg <= 1'b0;
    if (chipReset) begin
      busState <= BUS_IDLE;
      bitCntReg <= 4'h0;
      shiftReg <= 8'h00;
      ptrReg <= 8'h00;
      rwReg <= 1'b0;
      masterNackReg <= 1'b0;
      wrAddrReg <= 8'h00;
      wrDataReg <= 8'h00;
      sdaOe_n <= 1'b1;
    end else if (startSeen) begin
      busState <= lms_pkg::BUS_ADDR;
      bitCntReg <= 4'h0;
      sdaOe_n <= 1'b1;
    end else if (stopSeen) begin
      busState <= BUS_IDLE;
      sdaOe_n <= 1'b1;
    end else if (sclRise) begin
      if (busState == lms_pkg::BUS_ADDR || busState == BUS_PTR ||
          busState == BUS_WDATA) begin
        shiftReg <= {shiftReg[6:0], sdaS};
        bitCntReg <= bitCntReg + 4'h1;
      end else if (busState == BUS_RDATA_ACK) begin
        masterNackReg <= sdaS;
      end
    end else if (sclFall) begin
      unique case (busState)
        BUS_IDLE: begin
          sdaOe_n <= 1'b1;
        end
        lms_pkg::BUS_ADDR: begin
          // the bare name is the address parameter, not the state
          if (byteDone && shiftReg[7:1] == BUS_ADDR) begin
            busState <= BUS_ADDR_ACK;
            rwReg <= shiftReg[0];
            sdaOe_n <= 1'b0;
          end else if (byteDone) begin
            busState <= BUS_IDLE;
          end
        end
        BUS_ADDR_ACK: begin
          if (rwReg) begin
            busState <= BUS_RDATA;
            sdaOe_n <= readData[7];
            shiftReg <= {readData[6:0], 1'b0};
            bitCntReg <= 4'h1;
          end else begin
            busState <= BUS_PTR;
            sdaOe_n <= 1'b1;
            bitCntReg <= 4'h0;
          end
        end
        BUS_PTR: begin
          if (byteDone) begin
            ptrReg <= shiftReg;
            busState <= BUS_PTR_ACK;
            sdaOe_n <= 1'b0;
          end
        end
        BUS_PTR_ACK, BUS_WDATA_ACK: begin
          busState <= BUS_WDATA;
          sdaOe_n <= 1'b1;
          bitCntReg <= 4'h0;
        end
        BUS_WDATA: begin
          // accepted in every mode but reset, standby included
          if (byteDone) begin
            wrStrobeReg <= 1'b1;
            wrAddrReg <= ptrReg;
            wrDataReg <= shiftReg;
            ptrReg <= ptrReg + 8'h01;
            busState <= BUS_WDATA_ACK;
            sdaOe_n <= 1'b0;
          end
        end
        BUS_RDATA: begin
          if (byteDone) begin
            sdaOe_n <= 1'b1;
            ptrReg <= ptrReg + 8'h01;
            busState <= BUS_RDATA_ACK;
          end else begin
            sdaOe_n <= shiftReg[7];
            shiftReg <= {shiftReg[6:0], 1'b0};
            bitCntReg <= bitCntReg + 4'h1;
          end
        end
        BUS_RDATA_ACK: begin
          if (masterNackReg) begin
            busState <= BUS_IDLE;
          end else begin
            busState <= BUS_RDATA;
            sdaOe_n <= readData[7];
            shiftReg <= {readData[6:0], 1'b0};
            bitCntReg <= 4'h1;
          end
        end
      endcase
    end
  end

  // open drain: the line is only ever pulled low
  always_ff @(posedge clk) begin
    sdaOut <= 1'b0;
  end

  // whole-byte writes, so any bits change together
  always_ff @(posedge clk) begin
    if (chipReset) begin
      ctrlReg <= `LMS_CTRL_RESET;
      boostOutReg <= `LMS_BOOST_OUT_RESET;
    end else if (wrStrobeReg) begin
      if (wrAddrReg == `LMS_ADDR_CTRL) begin
        ctrlReg <= {5'h00, wrDataReg[2:0]};
      end else if (wrAddrReg == `LMS_ADDR_BOOST_OUT) begin
        boostOutReg <= wrDataReg;
      end
    end
  end

  assign runReq = ctrlReg[`LMS_CTRL_RUN_BIT];
  assign boostEn = ctrlReg[`LMS_CTRL_BOOST_BIT];
  assign loadEn = ctrlReg[`LMS_CTRL_LOAD_BIT];

  // thermal event restarts the oscillator delay
  assign startupClear = (modeReg != MODE_STARTUP) || tsdS;
  assign softClear = (modeReg != MODE_BOOST_START);

  lms_delay_timer #(
    .CYCLES(STARTUP_CYC)
  ) u_startup_timer (
    .clk(clk),
    .rst_n(rst_n),
    .clear(startupClear),
    .done(startupDone)
  );

  lms_delay_timer #(
    .CYCLES(SOFTSTART_CYC)
  ) u_soft_timer (
    .clk(clk),
    .rst_n(rst_n),
    .clear(softClear),
    .done(softDone)
  );

  always_ff @(posedge clk) begin
    if (chipReset) begin
      modeReg <= MODE_RESET;
    end else begin
      unique case (modeReg)
        MODE_RESET: begin
          modeReg <= MODE_STANDBY;
        end
        MODE_STANDBY: begin
          if (runReq) begin
            modeReg <= MODE_STARTUP;
          end
        end
        MODE_STARTUP: begin
          if (!runReq) begin
            modeReg <= MODE_STANDBY;
          end else if (!tsdS && startupDone && boostEn) begin
            modeReg <= MODE_BOOST_START;
          end else if (!tsdS && startupDone) begin
            modeReg <= MODE_NORMAL;
          end
        end
        MODE_BOOST_START: begin
          if (!runReq) begin
            modeReg <= MODE_STANDBY;
          end else if (tsdS) begin
            modeReg <= MODE_STARTUP;
          end else if (!boostEn || softDone) begin
            modeReg <= MODE_NORMAL;
          end
        end
        MODE_NORMAL: begin
          if (!runReq) begin
            modeReg <= MODE_STANDBY;
          end else if (tsdS) begin
            modeReg <= MODE_STARTUP;
          end else if (boostEn && !boostActiveReg) begin
            modeReg <= MODE_BOOST_START;
          end
        end
        default: begin
          modeReg <= MODE_RESET;
        end
      endcase
    end
  end

  // converter running at full pulse width after its soft start
  always_ff @(posedge clk) begin
    if (chipReset) begin
      boostActiveReg <= 1'b0;
    end else if (modeReg == MODE_BOOST_START && softDone && boostEn &&
                 runReq && !tsdS) begin
      boostActiveReg <= 1'b1;
    end else if (!boostEn || modeReg != MODE_NORMAL) begin
      boostActiveReg <= 1'b0;
    end
  end

  assign boostRun = (modeReg == MODE_BOOST_START && boostEn) ||
                    (modeReg == MODE_NORMAL && boostActiveReg && boostEn);

  // outputs registered, one cycle behind the mode
  always_ff @(posedge clk) begin
    if (chipReset) begin
      modeOut <= MODE_RESET;
      internalBlocksOn <= 1'b0;
      ledForceOff <= 1'b1;
      boostSoftStart <= 1'b0;
      activeLoadOn <= 1'b0;
    end else begin
      modeOut <= modeReg;
      internalBlocksOn <= (modeReg == MODE_STARTUP) ||
                          (modeReg == MODE_BOOST_START) ||
                          (modeReg == MODE_NORMAL);
      ledForceOff <= (modeReg != MODE_NORMAL);
      boostSoftStart <= (modeReg == MODE_BOOST_START);
      activeLoadOn <= boostRun && loadEn;
    end
  end

  // register value clamped to the 8..20 range before use
  always_ff @(posedge clk) begin
    if (chipReset) begin
      boostOutSetting <= `LMS_VOUT_MIN;
    end else if (boostOutReg < `LMS_VOUT_MIN) begin
      boostOutSetting <= `LMS_VOUT_MIN;
    end else if (boostOutReg > `LMS_VOUT_MAX) begin
      boostOutSetting <= `LMS_VOUT_MAX;
    end else begin
      boostOutSetting <= boostOutReg;
    end
  end

  // pulse module output is already a flop
  lms_switch_pwm #(
    .PERIOD(PERIOD_CYC),
    .MIN_ON(MIN_ON_CYC),
    .MAX_ON(MAX_ON_CYC),
    .SOFT_ON(SOFT_ON_CYC)
  ) u_switch (
    .clk(clk),
    .rst_n(!chipReset),
    .run(boostRun),
    .softStart(modeReg == MODE_BOOST_START),
    .activeLoad(loadEn),
    .currentTrip(tripS),
    .feedbackHigh(fbHighS),
    .switchOn(boostSwitch)
  );
endmodule

// ==== rtl/lms_defs.svh ====
// Purpose: constants of the lighting mode sequencer
// Assumes: clk is the internal oscillator at its nominal rate
// Notes: times are kept in their own units; counts derive in the code
`ifndef LMS_DEFS_SVH
`define LMS_DEFS_SVH

// oscillator and timing figures
`define LMS_CLK_HZ 10000000
`define LMS_CLK_PERIOD_NS 100
`define LMS_STARTUP_MS 10
`define LMS_SOFTSTART_MS 20
`define LMS_SWITCH_HZ 1000000
`define LMS_MIN_PULSE_NS 45
`define LMS_MAX_DUTY_PCT 90
`define LMS_SOFT_DUTY_PCT 20

// serial bus slave address, value is arbitrary
`define LMS_BUS_ADDR 7'h2A

// register offsets
`define LMS_ADDR_BOOST_OUT 8'h0D
`define LMS_ADDR_CTRL 8'h10
`define LMS_ADDR_STATUS 8'h11

// control register fields
`define LMS_CTRL_RUN_BIT 0
`define LMS_CTRL_BOOST_BIT 1
`define LMS_CTRL_LOAD_BIT 2

// reset values and output-voltage limits
`define LMS_CTRL_RESET 8'h04
`define LMS_BOOST_OUT_RESET 8'h08
`define LMS_VOUT_MIN 8'h08
`define LMS_VOUT_MAX 8'h14

`endif

// ==== rtl/lms_pkg.sv ====
// Purpose: types shared by the mode sequencer files
// Assumes: nothing
// Notes: state codes are Gray along the usual path
package lms_pkg;

  typedef enum logic [2:0] {
    MODE_RESET = 3'h0,
    MODE_STANDBY = 3'h1,
    MODE_STARTUP = 3'h3,
    MODE_BOOST_START = 3'h2,
    MODE_NORMAL = 3'h6
  } lms_mode_type;

  typedef enum logic [3:0] {
    BUS_IDLE = 4'h0,
    BUS_ADDR = 4'h1,
    BUS_ADDR_ACK = 4'h3,
    BUS_PTR = 4'h2,
    BUS_PTR_ACK = 4'h6,
    BUS_WDATA = 4'h7,
    BUS_WDATA_ACK = 4'h5,
    BUS_RDATA = 4'hD,
    BUS_RDATA_ACK = 4'hC
  } lms_bus_type;

endpackage

// ==== rtl/lms_delay_timer.sv ====
// Purpose: one-shot delay counted in oscillator cycles
// Assumes: clear is high while the delay is not wanted
// Notes: done stays high until clear returns
`timescale 1ns/100ps
module lms_delay_timer #(
  parameter int CYCLES = 100000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  output logic done
);
  localparam int W = $clog2(CYCLES + 1);

  logic [W-1:0] countReg;

  if (CYCLES < 1) begin : g_chk
    $error("delay must be at least one cycle");
  end

  always_ff @(posedge clk) begin
    if (!rst_n || clear) begin
      countReg <= '0;
      done <= 1'b0;
    end else if (countReg == W'(CYCLES - 1)) begin
      done <= 1'b1;
    end else begin
      countReg <= countReg + 1'b1;
    end
  end
endmodule

// ==== rtl/lms_switch_pwm.sv ====
// Purpose: boost switch pulse timing
// Assumes: currentTrip and feedbackHigh already synchronised
// Notes: the analog loop only ends or skips a pulse; timing is all digital
`timescale 1ns/100ps
module lms_switch_pwm #(
  parameter int PERIOD = 10,
  parameter int MIN_ON = 1,
  parameter int MAX_ON = 9,
  parameter int SOFT_ON = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic softStart,
  input wire logic activeLoad,
  input wire logic currentTrip,
  input wire logic feedbackHigh,
  output logic switchOn
);
  localparam int W = $clog2(PERIOD + 1);

  logic [W-1:0] phaseReg;
  logic [W-1:0] onCntReg;
  logic [W-1:0] onLimit;
  logic [W-1:0] onElapsed;
  logic skip;

  if (MIN_ON < 1 || MAX_ON >= PERIOD || SOFT_ON < MIN_ON ||
      SOFT_ON > MAX_ON) begin : g_chk
    $error("switch pulse limits do not fit the period");
  end

  // low-current soft start caps the pulse well below the duty limit
  assign onLimit = softStart ? W'(SOFT_ON) : W'(MAX_ON);
  assign onElapsed = onCntReg + 1'b1;
  // skipping only allowed with the active load switched off
  assign skip = !activeLoad && feedbackHigh;

  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      phaseReg <= '0;
    end else if (phaseReg == W'(PERIOD - 1)) begin
      phaseReg <= '0;
    end else begin
      phaseReg <= phaseReg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      switchOn <= 1'b0;
      onCntReg <= '0;
    end else if (phaseReg == W'(PERIOD - 1)) begin
      switchOn <= !skip;
      onCntReg <= '0;
    end else if (switchOn) begin
      onCntReg <= onElapsed;
      // trip ends the pulse only after the minimum width
      if (onElapsed >= onLimit) begin
        switchOn <= 1'b0;
      end else if (currentTrip && onElapsed >= W'(MIN_ON)) begin
        switchOn <= 1'b0;
      end
    end
  end
endmodule

// ==== tb/lms_host_model.sv ====
// Purpose: host side of the two-wire register bus
// Assumes: sdaLine is the resolved wire with its pull-up
// Notes: seven clk cycles with scl low, six with scl high, data moved while scl low
`timescale 1ns/100ps
module lms_host_model (
  input wire logic clk,
  input wire logic sdaLine,
  output logic scl,
  output logic sdaDrive
);
  initial begin
    scl = 1'b1;
    sdaDrive = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask

  task automatic put_bit(input logic b);
    tick(1);
    sdaDrive = b;
    tick(6);
    scl = 1'b1;
    tick(6);
    scl = 1'b0;
  endtask

  // released line so the device may pull it low
  task automatic get_bit(output logic b);
    tick(1);
    sdaDrive = 1'b1;
    tick(6);
    scl = 1'b1;
    tick(3);
    b = sdaLine;
    tick(3);
    scl = 1'b0;
  endtask

  task automatic start_cond();
    sdaDrive = 1'b1;
    tick(6);
    scl = 1'b1;
    tick(6);
    sdaDrive = 1'b0;
    tick(6);
    scl = 1'b0;
  endtask

  task automatic stop_cond();
    tick(1);
    sdaDrive = 1'b0;
    tick(6);
    scl = 1'b1;
    tick(6);
    sdaDrive = 1'b1;
    tick(6);
  endtask

  task automatic byte_out(input logic [7:0] d, output logic nack);
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(nack);
  endtask

  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
      input logic [7:0] data, output logic ok);
    logic n0, n1, n2;
    start_cond();
    byte_out({dev, 1'b0}, n0);
    byte_out(ptr, n1);
    byte_out(data, n2);
    stop_cond();
    ok = !(n0 | n1 | n2);
  endtask

  task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr,
      output logic [7:0] data, output logic ok);
    logic n0, n1, n2;
    start_cond();
    byte_out({dev, 1'b0}, n0);
    byte_out(ptr, n1);
    start_cond();
    byte_out({dev, 1'b1}, n2);
    for (int i = 7; i >= 0; i--) get_bit(data[i]);
    put_bit(1'b1);
    stop_cond();
    ok = !(n0 | n1 | n2);
  endtask
endmodule

// ==== tb/lms_mode_seq_properties.sv ====
// Purpose: timing checks on the mode sequencer ports
// Assumes: single clock domain, rst_n synchronous
// Notes: two-sample guards absorb one cycle of flop skew
`timescale 1ns/100ps
`include "lms_defs.svh"
module lms_mode_seq_properties #(
  parameter int STARTUP_CYC = 100000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic externalResetLow,
  input wire logic porActive,
  input wire logic thermalShutdownEvent,
  input wire lms_pkg::lms_mode_type modeOut,
  input wire logic internalBlocksOn,
  input wire logic ledForceOff,
  input wire logic boostSoftStart,
  input wire logic boostSwitch,
  input wire logic activeLoadOn,
  input wire logic [7:0] boostOutSetting
);
  import lms_pkg::*;
  logic [3:0] onCnt;
  int stCnt;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // saturates so a stuck switch cannot wrap back into range
  always_ff @(posedge clk) begin
    if (!rst_n || !boostSwitch) onCnt <= 4'h0;
    else if (onCnt != 4'hF) onCnt <= onCnt + 4'h1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n || modeOut != MODE_STARTUP) stCnt <= 0;
    else stCnt <= stCnt + 1;
  end

  ext_reset_a: assert property (
    !externalResetLow [*5] |-> modeOut == MODE_RESET && !internalBlocksOn
    && boostOutSetting == 8'h08 && ledForceOff)
    else $error("pin reset did not restore defaults");
  por_release_a: assert property (
    $fell(porActive) && externalResetLow |-> ##[2:6] modeOut == MODE_STANDBY)
    else $error("no standby after power-on reset");
  standby_quiet_a: assert property (
    modeOut == MODE_STANDBY && $past(modeOut) == MODE_STANDBY |->
    !internalBlocksOn && !boostSwitch && !activeLoadOn && !boostSoftStart)
    else $error("functions active in standby");
  startup_len_a: assert property (
    $past(modeOut) == MODE_STARTUP && modeOut inside {MODE_BOOST_START,
    MODE_NORMAL} |-> stCnt >= STARTUP_CYC + 1)
    else $error("startup delay cut short");
  thermal_hold_a: assert property (
    thermalShutdownEvent [*6] |-> modeOut != MODE_NORMAL &&
    modeOut != MODE_BOOST_START && !boostSwitch)
    else $error("running during thermal event");
  led_blank_a: assert property (
    modeOut != MODE_NORMAL && $past(modeOut) != MODE_NORMAL |-> ledForceOff)
    else $error("leds not blanked outside normal mode");
  soft_pulse_a: assert property (
    boostSoftStart |-> onCnt <= 4'h2)
    else $error("soft start pulse too wide");
  max_duty_a: assert property (
    onCnt <= 4'h9)
    else $error("switch pulse above duty limit");
  period_pulse_a: assert property (
    $rose(boostSwitch) && activeLoadOn && modeOut == MODE_NORMAL |-> ##10
    ($rose(boostSwitch) || !activeLoadOn || modeOut != MODE_NORMAL))
    else $error("switch period missed a pulse");
  clamp_range_a: assert property (
    boostOutSetting inside {[`LMS_VOUT_MIN:`LMS_VOUT_MAX]})
    else $error("output setting outside clamp");
endmodule

bind lms_mode_seq lms_mode_seq_properties #(.STARTUP_CYC(STARTUP_CYC))
  u_lms_mode_seq_properties (.clk(clk), .rst_n(rst_n),
  .externalResetLow(externalResetLow), .porActive(porActive),
  .thermalShutdownEvent(thermalShutdownEvent), .modeOut(modeOut),
  .internalBlocksOn(internalBlocksOn), .ledForceOff(ledForceOff),
  .boostSoftStart(boostSoftStart), .boostSwitch(boostSwitch),
  .activeLoadOn(activeLoadOn), .boostOutSetting(boostOutSetting));

// ==== tb/lms_mode_seq_test.sv ====
// Purpose: register-driven tests of the mode sequencer
// Assumes: shortened delay counts, host model on the bus
// Notes: bus writes take hundreds of cycles, so timing is forked
`timescale 1ns/100ps
`include "lms_defs.svh"
`define CHECK(nm, exp, got) begin \
  testsRun++; \
  if ((got) !== (exp)) begin \
    errorCnt++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); \
  end \
end
module lms_mode_seq_test;
  import lms_pkg::*;
  localparam int ST_CYC = 60;
  localparam int SS_CYC = 120;
  localparam logic [6:0] DEV = `LMS_BUS_ADDR;
  logic clk = 1'b0, rst_n = 1'b0, externalResetLow = 1'b1, porActive = 1'b0;
  logic thermalShutdownEvent = 1'b0, currentTrip = 1'b0, feedbackHigh = 1'b0;
  logic scl, hostSda, sdaOut, sdaOe_n, internalBlocksOn, ledForceOff;
  logic boostSoftStart, boostSwitch, activeLoadOn, ok;
  logic [7:0] boostOutSetting, v, e;
  logic [7:0] clampVals [7] = '{8'h00, 8'h07, 8'h08, 8'h0C, 8'h14, 8'h15,
    8'hFF};
  lms_mode_type modeOut;
  int errorCnt = 0, testsRun = 0, cycles = 0, n, lo;
  wire sdaWire = hostSda & (sdaOe_n | sdaOut);

  always #50 clk = ~clk;

  lms_mode_seq #(.STARTUP_CYC(ST_CYC), .SOFTSTART_CYC(SS_CYC)) u_lms_mode_seq (
    .clk(clk), .rst_n(rst_n), .externalResetLow(externalResetLow),
    .porActive(porActive), .thermalShutdownEvent(thermalShutdownEvent),
    .sclIn(scl), .sdaIn(sdaWire), .currentTrip(currentTrip),
    .feedbackHigh(feedbackHigh), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n),
    .modeOut(modeOut), .internalBlocksOn(internalBlocksOn),
    .ledForceOff(ledForceOff), .boostSoftStart(boostSoftStart),
    .boostSwitch(boostSwitch), .activeLoadOn(activeLoadOn),
    .boostOutSetting(boostOutSetting));
  lms_host_model u_lms_host_model (.clk(clk), .sdaLine(sdaWire), .scl(scl),
    .sdaDrive(hostSda));

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #10;
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    u_lms_host_model.write_reg(DEV, p, d, ok);
    `CHECK("write ack", 1'b1, ok)
  endtask

  task automatic rd(input logic [7:0] p, input logic [7:0] x);
    logic [7:0] d;
    u_lms_host_model.read_reg(DEV, p, d, ok);
    `CHECK("read ack", 1'b1, ok)
    `CHECK("read data", x, d)
  endtask

  // cycles spent in mode m, and how many of them had leds blanked
  task automatic count_mode(input lms_mode_type m, output int c,
      output int b);
    int w;
    c = 0;
    b = 0;
    w = 0;
    while (modeOut !== m && w < 1000) begin
      tick(1);
      w++;
    end
    while (modeOut === m && c < 1000) begin
      c++;
      if (ledForceOff === 1'b1) b++;
      tick(1);
    end
  endtask

  task automatic duty(output int c);
    c = 0;
    repeat (10) begin
      tick(1);
      if (boostSwitch === 1'b1) c++;
    end
  endtask

  task automatic closeOut();
    $display("checks %0d mismatches %0d", testsRun, errorCnt);
    if (errorCnt == 0 && testsRun > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 50000) begin
      errorCnt++;
      closeOut();
    end
  end

  initial begin
    tick(4);
    rst_n = 1'b1;
    // synchronisers refill first, so the mode shows at the fourth edge
    tick(4);
    `CHECK("mode", MODE_STANDBY, modeOut)
    `CHECK("blocks", 1'b0, internalBlocksOn)
    rd(`LMS_ADDR_CTRL, `LMS_CTRL_RESET);
    rd(`LMS_ADDR_BOOST_OUT, `LMS_BOOST_OUT_RESET);
    wr(8'h20, 8'hAA);
    rd(8'h20, 8'h00);
    foreach (clampVals[i]) begin
      v = clampVals[i];
      e = v < `LMS_VOUT_MIN ? `LMS_VOUT_MIN :
        (v > `LMS_VOUT_MAX ? `LMS_VOUT_MAX : v);
      wr(`LMS_ADDR_BOOST_OUT, v);
      tick(2);
      `CHECK("clamp", e, boostOutSetting)
    end
    rd(`LMS_ADDR_BOOST_OUT, 8'hFF);
    `CHECK("mode", MODE_STANDBY, modeOut)
    u_lms_host_model.write_reg(7'h15, `LMS_ADDR_CTRL, 8'h07, ok);
    `CHECK("foreign ack", 1'b0, ok)
    fork
      wr(`LMS_ADDR_CTRL, 8'h07);
      count_mode(MODE_STARTUP, n, lo);
    join
    `CHECK("startup len", ST_CYC + 1, n)
    count_mode(MODE_BOOST_START, n, lo);
    `CHECK("soft len", SS_CYC + 1, n)
    `CHECK("soft blank", n, lo)
    tick(12);
    `CHECK("leds", 1'b0, ledForceOff)
    `CHECK("load", 1'b1, activeLoadOn)
    duty(n);
    `CHECK("duty", 9, n)
    currentTrip = 1'b1;
    tick(12);
    duty(n);
    `CHECK("min pulse", 1, n)
    currentTrip = 1'b0;
    wr(`LMS_ADDR_CTRL, 8'h03);
    feedbackHigh = 1'b1;
    tick(12);
    duty(n);
    `CHECK("skip", 0, n)
    `CHECK("load off", 1'b0, activeLoadOn)
    feedbackHigh = 1'b0;
    thermalShutdownEvent = 1'b1;
    tick(60);
    `CHECK("thermal", MODE_STARTUP, modeOut)
    duty(n);
    `CHECK("thermal sw", 0, n)
    thermalShutdownEvent = 1'b0;
    count_mode(MODE_BOOST_START, n, lo);
    `CHECK("resoft len", SS_CYC + 1, n)
    wr(`LMS_ADDR_CTRL, 8'h05);
    tick(12);
    duty(n);
    `CHECK("boost off", 0, n)
    `CHECK("mode", MODE_NORMAL, modeOut)
    fork
      wr(`LMS_ADDR_CTRL, 8'h07);
      count_mode(MODE_BOOST_START, n, lo);
    join
    `CHECK("boost again", SS_CYC + 1, n)
    wr(`LMS_ADDR_CTRL, 8'h05);
    wr(`LMS_ADDR_BOOST_OUT, 8'h08);
    wr(`LMS_ADDR_CTRL, 8'h00);
    tick(4);
    `CHECK("standby", MODE_STANDBY, modeOut)
    rd(`LMS_ADDR_STATUS, {5'h00, MODE_STANDBY});
    wr(`LMS_ADDR_BOOST_OUT, 8'h10);
    wr(`LMS_ADDR_CTRL, 8'h03);
    externalResetLow = 1'b0;
    tick(6);
    `CHECK("pin reset", MODE_RESET, modeOut)
    externalResetLow = 1'b1;
    tick(6);
    rd(`LMS_ADDR_CTRL, `LMS_CTRL_RESET);
    rd(`LMS_ADDR_BOOST_OUT, `LMS_BOOST_OUT_RESET);
    porActive = 1'b1;
    tick(6);
    `CHECK("por", MODE_RESET, modeOut)
    porActive = 1'b0;
    tick(6);
    `CHECK("por release", MODE_STANDBY, modeOut)
    closeOut();
  end
endmodule
